// File: src/level_irq_status.sv
// Level-mode serial interrupt status flags with write-one re-arm
`timescale 1ns/1ns
`default_nettype none
module level_irq_status
  import prefetch_limits_pkg::*;
#(
  parameter int LINES = IRQ_LINES
) (
  // Clock and resets
  input wire logic clk,
  input wire logic coldReset,
  // Serial frame decode
  input wire logic [LINES-1:0] lineAsserted,
  input wire logic [LINES-1:0] levelMode,
  // Software re-arm
  input wire logic [LINES-1:0] rearmMask,
  output logic [LINES-1:0] statusFlags
);
  logic [LINES-1:0] flags_r;
  logic [LINES-1:0] flags_nxt;

  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : gLine
      // Set wins over a same-cycle re-arm so no assertion is lost
      always_comb begin
        if (levelMode[g] && lineAsserted[g]) begin // R11 R13
          flags_nxt[g] = 1'b1;
        end else if (rearmMask[g]) begin // R12
          flags_nxt[g] = 1'b0;
        end else begin
          flags_nxt[g] = flags_r[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (coldReset) begin // R10
      flags_r <= IRQ_STATUS_RESET[LINES-1:0];
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign statusFlags = flags_r;
endmodule : level_irq_status
`default_nettype wire

// File: src/prefetch_burst_counter.sv
// Counts pre-fetch reads issued within one upstream read burst
`timescale 1ns/1ns
`default_nettype none
module prefetch_burst_counter
  import prefetch_limits_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic start,
  input wire logic issued,
  input wire logic [3:0] limit,
  output logic more
);
  logic [3:0] count_r;
  logic [3:0] count_nxt;

  always_comb begin
    count_nxt = count_r;
    if (start) begin
      count_nxt = 4'h0;
    end else if (issued && more) begin
      count_nxt = count_r + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count_r <= 4'h0;
    end else begin
      count_r <= count_nxt;
    end
  end

  // Initial read is not counted: limit-1 further reads allowed
  assign more = (limit > COUNT_SINGLE) && (count_r < (limit - COUNT_SINGLE)); // R3
endmodule : prefetch_burst_counter
`default_nettype wire

// File: src/prefetch_limits_pkg.sv
// Package: register map, field layout and encodings of the pre-fetch limits block
package prefetch_limits_pkg;
  localparam logic [7:0] PREFETCH_LIMITS_OFFSET = 8'he8;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'he4;
  localparam logic [7:0] IRQ_EDGE_CTRL_OFFSET = 8'he2;
  localparam logic [15:0] PREFETCH_LIMITS_RESET = 16'h0443;
  localparam logic [15:0] PREFETCH_LIMITS_WMASK = 16'h0fcf;
  localparam logic [15:0] IRQ_STATUS_RESET = 16'h0000;
  localparam int COUNT_LSB = 8;
  localparam int COUNT_MSB = 11;
  localparam int CACHE_LSB = 6;
  localparam int CACHE_MSB = 7;
  localparam int LENGTH_LSB = 0;
  localparam int LENGTH_MSB = 3;
  localparam int IRQ_LINES = 16;
  localparam logic [3:0] COUNT_DISABLED = 4'h0;
  localparam logic [3:0] COUNT_SINGLE = 4'h1;
  localparam logic [3:0] LENGTH_MAX_CODE = 4'h7;
  localparam logic [13:0] LENGTH_BASE_BYTES = 14'h0040;
  typedef enum logic [1:0] {
    CACHE_NONE = 2'b00,
    CACHE_LIGHT = 2'b01,
    CACHE_FULL = 2'b10,
    CACHE_RSVD = 2'b11
  } cache_mode_e;
  typedef enum logic [1:0] {
    AGENT_IDLE = 2'b00,
    AGENT_FETCH = 2'b01,
    AGENT_HOLD = 2'b10
  } agent_state_e;
endpackage : prefetch_limits_pkg

// File: src/upstream_read_prefetch_limits.sv
// Pre-fetch agent limits register, caching policy and level interrupt status
//
// Contract
// R1: Count zero disables the pre-fetch agent; no pre-fetch reads issued.
// R2: Count one limits each thread to one buffer, no pre-fetch reads.
// R3: Counts two to fifteen allow initial read plus count-minus-one pre-fetches.
// R4: Cache mode 00: no prefetch, discard leftovers after any data returned.
// R5: Mode 01: prefetch; discard if master ended, cache if bridge retried.
// R6: Mode 10: prefetch and always cache leftovers; mode 11 reserved.
// R7: Length codes 0-7 select 64 bytes to 8 Kbytes; 8-15 reserved.
// R8: Limits register at E8h, resets to 0443h.
// R9: Bits 15:12 and 5:4 read zero; writes to them ignored.
// R10: Fields and status cleared by fundamental, global or power-on reset only.
// R11: Status bits read 1 once their line asserted, 0 when deasserted. The code keeps a bit at 1 after deassertion until a write of 1 re-arms it.
// R12: Writing 1 to an asserted status bit re-arms it by clearing.
// R13: Edge-mode lines never set their status bit.
// R14: Software must not program reserved cache or length codes.
`timescale 1ns/1ns
`default_nettype none
module upstream_read_prefetch_limits
  import prefetch_limits_pkg::*;
(
  // Clock and resets
  input wire logic clk,
  input wire logic reset,
  input wire logic link_fundamental_reset_n,
  input wire logic global_reset_n,
  input wire logic hotReset,
  // Configuration access
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire logic [7:0] cfgAddr,
  input wire logic [1:0] cfgByteEn,
  input wire logic [15:0] cfgWrData,
  output logic [15:0] cfgRdData,
  // Serial interrupt frame decode
  input wire logic [IRQ_LINES-1:0] irqLineAsserted,
  input wire logic [IRQ_LINES-1:0] irqLevelMode,
  // Upstream read thread
  input wire logic threadStart,
  input wire logic prefetchIssued,
  input wire logic dataReturned,
  input wire logic masterTerminated,
  input wire logic bridgeRetry,
  output logic prefetchRequest,
  output logic [13:0] threadByteLimit,
  output logic cacheLeftover,
  output logic discardLeftover,
  // Decoded limits
  output logic [3:0] prefetch_count_limit,
  output logic [1:0] completion_cache_mode,
  output logic [3:0] prefetch_length_limit
);
  // ****************************************
  // Reset and pin synchronisation
  // ****************************************
  logic [1:0] fundSync_r;
  logic [1:0] fundSync_nxt;
  logic [1:0] globSync_r;
  logic [1:0] globSync_nxt;
  logic coldReset;

  // Second stage alone feeds the logic below
  always_comb begin
    fundSync_nxt = {fundSync_r[0], link_fundamental_reset_n};
    globSync_nxt = {globSync_r[0], global_reset_n};
  end

  // Stages clear to zero so registers stay in reset until the pins prove high
  always_ff @(posedge clk) begin
    if (reset) begin
      fundSync_r <= 2'b00;
      globSync_r <= 2'b00;
    end else begin
      fundSync_r <= fundSync_nxt;
      globSync_r <= globSync_nxt;
    end
  end

  // Hot reset deliberately left out: these bits survive it
  assign coldReset = reset || !fundSync_r[1] || !globSync_r[1]; // R10

  // ****************************************
  // Limits register
  // ****************************************
  logic [15:0] limits_r;
  logic [15:0] limits_nxt;
  logic [15:0] laneMask;
  logic limitsHit;
  logic statusHit;

  localparam int LANE_BITS = 8;

  function automatic logic [15:0] lane_mask(input logic [1:0] be);
    lane_mask = {{LANE_BITS{be[1]}}, {LANE_BITS{be[0]}}};
  endfunction : lane_mask

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
    reg_hit = (addr == offset);
  endfunction : reg_hit

  assign laneMask = lane_mask(cfgByteEn);
  assign limitsHit = reg_hit(cfgAddr, PREFETCH_LIMITS_OFFSET); // R8
  assign statusHit = reg_hit(cfgAddr, IRQ_STATUS_OFFSET);

  always_comb begin
    limits_nxt = limits_r;
    if (cfgWrite && limitsHit) begin
      // Reserved bits masked out of every write
      limits_nxt = (limits_r & ~(laneMask & PREFETCH_LIMITS_WMASK))
                 | (cfgWrData & laneMask & PREFETCH_LIMITS_WMASK); // R9
    end
  end

  always_ff @(posedge clk) begin
    if (coldReset) begin
      limits_r <= PREFETCH_LIMITS_RESET; // R8 R10
    end else begin
      limits_r <= limits_nxt;
    end
  end

  // Fields leave straight from the register flops
  assign prefetch_count_limit = limits_r[COUNT_MSB:COUNT_LSB];
  assign completion_cache_mode = limits_r[CACHE_MSB:CACHE_LSB];
  assign prefetch_length_limit = limits_r[LENGTH_MSB:LENGTH_LSB];

  // ****************************************
  // Interrupt status
  // ****************************************
  logic [IRQ_LINES-1:0] irqFlags;
  logic [IRQ_LINES-1:0] rearmMask;
  logic [1:0] irqSync0_r [IRQ_LINES];
  logic [IRQ_LINES-1:0] irqSynced;

  genvar g;
  generate
    for (g = 0; g < IRQ_LINES; g++) begin : gSync
      logic [1:0] lineSync_nxt;
      always_comb begin
        lineSync_nxt = {irqSync0_r[g][0], irqLineAsserted[g]};
      end
      always_ff @(posedge clk) begin
        if (reset) begin
          irqSync0_r[g] <= 2'b00;
        end else begin
          irqSync0_r[g] <= lineSync_nxt;
        end
      end
      assign irqSynced[g] = irqSync0_r[g][1];
    end
  endgenerate

  // Byte lanes gate the re-arm so a narrow write clears only its own bits
  assign rearmMask = (cfgWrite && statusHit) ? (cfgWrData & laneMask) : '0; // R12

  level_irq_status #(
    .LINES(IRQ_LINES)
  ) uStatus (
    .clk(clk),
    .coldReset(coldReset),
    .lineAsserted(irqSynced),
    .levelMode(irqLevelMode),
    .rearmMask(rearmMask),
    .statusFlags(irqFlags)
  );

  // ****************************************
  // Read data
  // ****************************************
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;
  logic [15:0] rdData_r;
  logic [15:0] rdData_nxt;

  // Held between reads so a late sample still sees the last answer
  always_comb begin
    rdData_nxt = rdData_r;
    if (cfgRead) begin
      if (limitsHit) begin
        rdData_nxt = limits_r & PREFETCH_LIMITS_WMASK; // R9
      end else if (statusHit) begin
        rdData_nxt = irqFlags; // R11
      end else begin
        rdData_nxt = UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdData_r <= UNMAPPED_READ;
    end else begin
      rdData_r <= rdData_nxt;
    end
  end

  assign cfgRdData = rdData_r;

  // ****************************************
  // Pre-fetch agent
  // ****************************************
  agent_state_e state_r;
  agent_state_e state_nxt;
  logic more;
  logic prefetchAllowed;
  logic [13:0] byteLimit_r;
  logic [13:0] byteLimit_nxt;
  logic cache_r;
  logic cache_nxt;
  logic discard_r;
  logic discard_nxt;
  localparam logic [13:0] NO_BYTE_LIMIT = 14'h0000;

  // Reserved length codes clamp to the largest size rather than wrapping
  function automatic logic [13:0] length_bytes(input logic [3:0] code);
    if (code > LENGTH_MAX_CODE) begin
      length_bytes = LENGTH_BASE_BYTES << LENGTH_MAX_CODE; // R7
    end else begin
      length_bytes = LENGTH_BASE_BYTES << code; // R7
    end
  endfunction : length_bytes

  // Reserved cache mode treated as no pre-fetch; safest reading
  assign prefetchAllowed = (prefetch_count_limit != COUNT_DISABLED) // R1
                         && (prefetch_count_limit != COUNT_SINGLE) // R2
                         && ((completion_cache_mode == CACHE_LIGHT)
                          || (completion_cache_mode == CACHE_FULL)); // R4 R5 R6

  // Counter clears on cold reset only; every thread start restarts it anyway
  prefetch_burst_counter uCount (
    .clk(clk),
    .reset(coldReset),
    .start(threadStart),
    .issued(prefetchIssued),
    .limit(prefetch_count_limit),
    .more(more)
  );

  always_comb begin
    state_nxt = state_r;
    byteLimit_nxt = byteLimit_r;
    cache_nxt = 1'b0;
    discard_nxt = 1'b0;
    case (state_r)
      AGENT_IDLE: begin
        if (threadStart) begin
          state_nxt = AGENT_FETCH;
          byteLimit_nxt = length_bytes(prefetch_length_limit); // R7
        end
      end
      AGENT_FETCH: begin
        // First returned data ends pre-fetching for this thread
        if (dataReturned) begin
          state_nxt = AGENT_HOLD;
        end
      end
      AGENT_HOLD: begin
        // Both ends in one cycle count as a master end: light mode discards
        if (masterTerminated || bridgeRetry) begin
          state_nxt = AGENT_IDLE;
          case (completion_cache_mode)
            CACHE_LIGHT: begin
              cache_nxt = bridgeRetry && !masterTerminated; // R5
              discard_nxt = masterTerminated; // R5
            end
            CACHE_FULL: begin
              cache_nxt = 1'b1; // R6
            end
            default: begin
              discard_nxt = 1'b1; // R4
            end
          endcase
        end
      end
      default: begin
        state_nxt = AGENT_IDLE;
      end
    endcase
  end

  // Hot reset idles the agent but leaves the register fields alone
  always_ff @(posedge clk) begin
    if (coldReset || hotReset) begin
      state_r <= AGENT_IDLE;
      byteLimit_r <= NO_BYTE_LIMIT;
      cache_r <= 1'b0;
      discard_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      byteLimit_r <= byteLimit_nxt;
      cache_r <= cache_nxt;
      discard_r <= discard_nxt;
    end
  end

  // Combinational handshake; drops once the last allowed read is counted
  assign prefetchRequest = (state_r == AGENT_FETCH) && prefetchAllowed && more; // R1 R2 R3
  assign threadByteLimit = byteLimit_r;
  assign cacheLeftover = cache_r;
  assign discardLeftover = discard_r;
endmodule : upstream_read_prefetch_limits
`default_nettype wire

// File: testbench/pci_read_master.sv
// Behavioural parallel-bus master issuing upstream read threads
`timescale 1ns/1ns
`default_nettype none
module pci_read_master (
  // Clock
  input wire logic clk,
  // Bridge answers
  input wire logic prefetchRequest,
  input wire logic cacheLeftover,
  input wire logic discardLeftover,
  // Thread events
  output logic threadStart,
  output logic prefetchIssued,
  output logic dataReturned,
  output logic masterTerminated,
  output logic bridgeRetry
);
  int issued;
  logic sawCache;
  logic sawDiscard;
  initial begin
    {threadStart, prefetchIssued, dataReturned, masterTerminated, bridgeRetry} = 5'h00;
  end
  // Issue every other cycle so the count lands before the next look
  task automatic run_thread(input logic retry);
    issued = 0;
    sawCache = 1'b0;
    sawDiscard = 1'b0;
    @(posedge clk) threadStart <= 1'b1;
    @(posedge clk) threadStart <= 1'b0;
    repeat (20) begin
      @(posedge clk) prefetchIssued <= prefetchRequest;
      issued += int'(prefetchRequest);
      @(posedge clk) prefetchIssued <= 1'b0;
    end
    @(posedge clk) dataReturned <= 1'b1;
    @(posedge clk) dataReturned <= 1'b0;
    @(posedge clk) {masterTerminated, bridgeRetry} <= {!retry, retry};
    @(posedge clk) {masterTerminated, bridgeRetry} <= 2'b00;
    repeat (3) begin
      @(posedge clk) sawCache |= cacheLeftover;
      sawDiscard |= discardLeftover;
    end
  endtask : run_thread
endmodule : pci_read_master
`default_nettype wire

// File: testbench/prefetch_limits_chk.sv
// Port checker for the pre-fetch limits block
`timescale 1ns/1ns
`default_nettype none
module prefetch_limits_chk
  import prefetch_limits_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Configuration access
  input wire logic cfgRead,
  input wire logic [7:0] cfgAddr,
  input wire logic [15:0] cfgRdData,
  // Upstream read thread
  input wire logic threadStart,
  input wire logic prefetchIssued,
  input wire logic masterTerminated,
  input wire logic bridgeRetry,
  input wire logic prefetchRequest,
  input wire logic [13:0] threadByteLimit,
  input wire logic cacheLeftover,
  input wire logic discardLeftover,
  // Decoded limits
  input wire logic [3:0] prefetch_count_limit,
  input wire logic [1:0] completion_cache_mode,
  input wire logic [3:0] prefetch_length_limit
);
  logic [4:0] issuedCnt_r;
  logic [4:0] issuedCnt_nxt;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  always_comb begin
    issuedCnt_nxt = threadStart ? 5'h00 : issuedCnt_r + {4'h0, prefetchIssued};
  end
  always_ff @(posedge clk) begin
    issuedCnt_r <= reset ? 5'h00 : issuedCnt_nxt;
  end
  property p_off; prefetch_count_limit == 4'h0 |-> !prefetchRequest; endproperty
  a_off: assert property (p_off) else $error("pre-fetch with count zero");
  property p_one; prefetch_count_limit == 4'h1 |-> !prefetchRequest; endproperty
  a_one: assert property (p_one) else $error("pre-fetch with count one");
  property p_cnt; prefetchRequest |-> issuedCnt_r + 5'h01 < {1'b0, prefetch_count_limit};
  endproperty
  a_cnt: assert property (p_cnt) else $error("too many pre-fetch reads");
  property p_none; completion_cache_mode == 2'b00 |-> !prefetchRequest; endproperty
  a_none: assert property (p_none) else $error("pre-fetch with caching off");
  property p_light;
    cacheLeftover && $past(masterTerminated && !bridgeRetry) |-> $past(completion_cache_mode) == 2'b10;
  endproperty
  a_light: assert property (p_light) else $error("cached after master end");
  property p_full; discardLeftover |-> $past(completion_cache_mode) != 2'b10; endproperty
  a_full: assert property (p_full) else $error("discard in full caching");
  property p_len; threadStart && prefetch_length_limit <= LENGTH_MAX_CODE
    |=> threadByteLimit == LENGTH_BASE_BYTES << $past(prefetch_length_limit); endproperty
  a_len: assert property (p_len) else $error("wrong thread byte limit");
  property p_rsvd; $past(cfgRead) && $past(cfgAddr) == PREFETCH_LIMITS_OFFSET |-> cfgRdData ==
    {4'h0, $past(prefetch_count_limit), $past(completion_cache_mode), 2'b00,
    $past(prefetch_length_limit)}; endproperty
  a_rsvd: assert property (p_rsvd) else $error("limits read value wrong");
endmodule : prefetch_limits_chk
`default_nettype wire

// File: testbench/upstream_read_prefetch_limits_test.sv
// Self-checking bench for the upstream read pre-fetch limits block
`timescale 1ns/1ns
`default_nettype none
module upstream_read_prefetch_limits_test;
  import prefetch_limits_pkg::*;
  logic clk, reset, linkResetN, globalResetN, hotReset, cfgWrite, cfgRead;
  logic threadStart, prefetchIssued, dataReturned, masterTerminated, bridgeRetry;
  logic prefetchRequest, cacheLeftover, discardLeftover;
  logic [7:0] cfgAddr;
  logic [15:0] cfgWrData, cfgRdData, irqLineAsserted, irqLevelMode, rd;
  logic [13:0] threadByteLimit;
  logic [3:0] countLimit, lengthLimit;
  logic [1:0] cacheMode, cfgByteEn;
  int err_count = 0;
  int tests_run = 0;
  upstream_read_prefetch_limits upstream_read_prefetch_limits_inst (.clk(clk), .reset(reset),
    .link_fundamental_reset_n(linkResetN), .global_reset_n(globalResetN), .hotReset(hotReset),
    .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
    .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .irqLineAsserted(irqLineAsserted),
    .irqLevelMode(irqLevelMode), .threadStart(threadStart), .prefetchIssued(prefetchIssued),
    .dataReturned(dataReturned), .masterTerminated(masterTerminated), .bridgeRetry(bridgeRetry),
    .prefetchRequest(prefetchRequest), .threadByteLimit(threadByteLimit),
    .cacheLeftover(cacheLeftover), .discardLeftover(discardLeftover),
    .prefetch_count_limit(countLimit), .completion_cache_mode(cacheMode),
    .prefetch_length_limit(lengthLimit));
  pci_read_master pci_read_master_inst (.clk(clk), .prefetchRequest(prefetchRequest),
    .cacheLeftover(cacheLeftover), .discardLeftover(discardLeftover), .threadStart(threadStart),
    .prefetchIssued(prefetchIssued), .dataReturned(dataReturned),
    .masterTerminated(masterTerminated), .bridgeRetry(bridgeRetry));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cfg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) {cfgWrite, cfgAddr, cfgWrData} <= {1'b1, a, d};
    @(posedge clk) cfgWrite <= 1'b0;
  endtask : cfg_write
  task automatic expect_reg(input string what, input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk) {cfgRead, cfgAddr} <= {1'b1, a};
    @(posedge clk) cfgRead <= 1'b0;
    @(posedge clk) check(what, cfgRdData, exp);
  endtask : expect_reg
  task automatic test_regs();
    expect_reg("limits reset", PREFETCH_LIMITS_OFFSET, 16'h0443);
    cfg_write(PREFETCH_LIMITS_OFFSET, 16'hfab7);
    expect_reg("limits reserved", PREFETCH_LIMITS_OFFSET, 16'h0a87);
    check("count field", {12'h000, countLimit}, 16'h000a);
    check("cache field", {14'h0000, cacheMode}, 16'h0002);
    check("length field", {12'h000, lengthLimit}, 16'h0007);
    cfgByteEn <= 2'b01;
    cfg_write(PREFETCH_LIMITS_OFFSET, 16'hf143);
    cfgByteEn <= 2'b11;
    expect_reg("low lane only", PREFETCH_LIMITS_OFFSET, 16'h0a43);
    expect_reg("unmapped", 8'he6, 16'h0000);
  endtask : test_regs
  task automatic test_count();
    logic [3:0] counts [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'hf};
    foreach (counts[i]) begin
      cfg_write(PREFETCH_LIMITS_OFFSET, {4'h0, counts[i], 8'h43});
      pci_read_master_inst.run_thread(1'b0);
      check("reads", 16'(pci_read_master_inst.issued),
        counts[i] > 4'h1 ? {12'h000, counts[i] - 4'h1} : 16'h0000);
    end
  endtask : test_count
  task automatic test_leftover();
    logic cache;
    for (int m = 0; m < 3; m++) begin
      for (int r = 0; r < 2; r++) begin
        cache = (m == 2) || (m == 1 && r == 1);
        cfg_write(PREFETCH_LIMITS_OFFSET, {8'h04, 2'(m), 6'h03});
        pci_read_master_inst.run_thread(r[0]);
        check("cached", {15'h0, pci_read_master_inst.sawCache}, {15'h0, cache});
        check("discarded", {15'h0, pci_read_master_inst.sawDiscard}, {15'h0, !cache});
        check("mode reads", 16'(pci_read_master_inst.issued), m == 0 ? 16'h0 : 16'h3);
      end
    end
  endtask : test_leftover
  task automatic test_length();
    for (int c = 0; c < 8; c++) begin
      cfg_write(PREFETCH_LIMITS_OFFSET, {12'h044, 4'(c)});
      pci_read_master_inst.run_thread(1'b0);
      check("byte limit", {2'b00, threadByteLimit}, 16'h0040 << c);
    end
  endtask : test_length
  task automatic test_irq_reset();
    irqLevelMode <= 16'h0003;
    irqLineAsserted <= 16'h0007;
    repeat (5) @(posedge clk);
    expect_reg("status set", IRQ_STATUS_OFFSET, 16'h0003);
    irqLineAsserted <= 16'h0006;
    repeat (5) @(posedge clk);
    cfg_write(IRQ_STATUS_OFFSET, 16'h0001);
    expect_reg("status rearm", IRQ_STATUS_OFFSET, 16'h0002);
    irqLineAsserted <= 16'h0000;
    cfg_write(PREFETCH_LIMITS_OFFSET, 16'h0281);
    hotReset <= 1'b1;
    @(posedge clk) hotReset <= 1'b0;
    expect_reg("hot reset", PREFETCH_LIMITS_OFFSET, 16'h0281);
    expect_reg("hot status", IRQ_STATUS_OFFSET, 16'h0002);
    for (int p = 0; p < 2; p++) begin
      cfg_write(PREFETCH_LIMITS_OFFSET, 16'h0281);
      {globalResetN, linkResetN} <= p ? 2'b01 : 2'b10;
      repeat (2) @(posedge clk);
      {globalResetN, linkResetN} <= 2'b11;
      repeat (4) @(posedge clk);
      expect_reg("cold reset", PREFETCH_LIMITS_OFFSET, 16'h0443);
      expect_reg("cold status", IRQ_STATUS_OFFSET, 16'h0000);
    end
  endtask : test_irq_reset
  task automatic end_sim();
    $display("checks run %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  initial begin
    {reset, linkResetN, globalResetN, hotReset, cfgWrite, cfgRead} = 6'b111000;
    {cfgAddr, cfgWrData, irqLineAsserted, irqLevelMode} = '0;
    cfgByteEn = 2'b11;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    test_regs();
    test_count();
    test_leftover();
    test_length();
    test_irq_reset();
    end_sim();
  end
endmodule : upstream_read_prefetch_limits_test
bind upstream_read_prefetch_limits prefetch_limits_chk prefetch_limits_chk_inst (.clk(clk),
  .reset(reset), .cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgRdData(cfgRdData),
  .threadStart(threadStart), .prefetchIssued(prefetchIssued), .bridgeRetry(bridgeRetry),
  .masterTerminated(masterTerminated), .prefetchRequest(prefetchRequest),
  .threadByteLimit(threadByteLimit), .cacheLeftover(cacheLeftover),
  .discardLeftover(discardLeftover), .prefetch_count_limit(prefetch_count_limit),
  .completion_cache_mode(completion_cache_mode), .prefetch_length_limit(prefetch_length_limit));
`default_nettype wire
